// File: rtl/cmp_edge_sync.sv
`timescale 1ns/1ps
module cmp_edge_sync (
	input  wire logic	clock,
	input  wire logic	rst_sync_n,
	input  wire logic	raw,
	edge_if.src	ev
);
	typedef struct packed {
		logic	s1;
		logic	s2;
		logic	s3;
	} st_t;
	st_t	st_r;
	st_t	st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = raw;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ev.level = st_r.s2;
	assign ev.rise  = st_r.s2 & ~st_r.s3;
	assign ev.fall  = ~st_r.s2 & st_r.s3;
endmodule

// File: rtl/cmp_regs_pkg.sv
package cmp_regs_pkg;
	localparam logic [7:0] ADDR_CMP1_CONTROL      = 8'h9A;
	localparam logic [7:0] ADDR_CMP0_CONTROL      = 8'h9B;
	localparam logic [7:0] ADDR_CMP0_MODE_SELECT  = 8'h9D;
	localparam logic [7:0] ADDR_CMP0_INPUT_SELECT = 8'h9F;
	localparam logic [7:0] ADDR_IRQ_STATUS        = 8'hA0;
	localparam logic [7:0] ADDR_IRQ_MASK          = 8'hA1;
	localparam logic [7:0] ADDR_CMP1_MODE_SELECT  = 8'hA2;
	localparam logic [7:0] RST_CONTROL            = 8'h00;
	localparam logic [7:0] RST_MODE               = 8'h02;
	localparam logic [7:0] RST_INPUT_SEL          = 8'h00;
	localparam logic [7:0] MASK_CONTROL_WR        = 8'h8F;
	localparam logic [7:0] MASK_FLAGS             = 8'h30;
	localparam logic [7:0] MASK_MODE              = 8'h33;
	localparam logic [7:0] MASK_INPUT_SEL         = 8'h77;
	localparam logic [3:0] MASK_IRQ               = 4'hF;
	localparam int         BIT_ON                 = 7;
	localparam int         BIT_RESULT             = 6;
	localparam int         BIT_RISE               = 5;
	localparam int         BIT_FALL               = 4;
	localparam int         BIT_RISE_EN            = 5;
	localparam int         BIT_FALL_EN            = 4;
	localparam int         NUM_CMP                = 2;
endpackage

// File: rtl/comparator_control_regs.sv
`timescale 1ns/1ps
// How it works
// - Enable bit seven powers the comparator; zero keeps it off.
// - Read-only bit six shows the comparator's live output state.
// - Rising output transition sets the rising flag.
// - Falling output transition sets the falling flag.
// - Two-bit positive hysteresis code drives the core: off, 5, 10, 20 mV.
// - Two-bit negative hysteresis code in low bits drives the core likewise.
// - Bits six to four select the negative input pin, codes 0 to 4.
// - Bits two to zero select the positive input pin, codes 0 to 4.
// - Input select bits seven and three read zero, ignore writes.
// - Two-bit speed field picks response mode, 0 fastest, 3 lowest power.
// - Rising flag requests interrupt only when rising enable is one.
// - Falling flag requests interrupt only when falling enable is one.
// - Mode register resets to 0x02, upper two bits read zero.
// - Mode register bits three and two read zero, ignore writes.
// - Second comparator control register at 0x9A, same layout.
// - Edge flags stay set until software writes zero to them.
// - A disabled comparator drives its port output low.
module comparator_control_regs (
	input  wire logic	clock,
	input  wire logic	rst_n,
	input  wire logic [7:0]	addr,
	input  wire logic [7:0]	wdata,
	input  wire logic	wr_stb,
	input  wire logic	rd_stb,
	output logic [7:0]	rdata,
	input  wire logic	cmp_a_raw,
	input  wire logic	cmp_b_raw,
	output logic	cmp_a_on,
	output logic	cmp_b_on,
	output logic [1:0]	cmp_a_pos_hyst,
	output logic [1:0]	cmp_a_neg_hyst,
	output logic [1:0]	cmp_b_pos_hyst,
	output logic [1:0]	cmp_b_neg_hyst,
	output logic [2:0]	cmp_a_neg_sel,
	output logic [2:0]	cmp_a_pos_sel,
	output logic [1:0]	cmp_a_speed_sel,
	output logic [1:0]	cmp_b_speed_sel,
	output logic	cmp_a_pin_out,
	output logic	cmp_b_pin_out,
	output logic	cmp_a_irq,
	output logic	cmp_b_irq,
	output logic	irq
);
	typedef struct packed {
		logic [7:0]	ctl_a;
		logic [7:0]	ctl_b;
		logic [7:0]	mode_a;
		logic [7:0]	mode_b;
		logic [7:0]	insel_a;
		logic [3:0]	ist;
		logic [3:0]	imask;
		logic [7:0]	rdata;
		logic	pin_a;
		logic	pin_b;
		logic	irq_a;
		logic	irq_b;
		logic	irq;
	} state_t;

	state_t	st_r;
	state_t	st_nxt;
	logic	rs1_r;
	logic	rs2_r;
	logic [7:0]	ctl_a_rd;
	logic [7:0]	ctl_b_rd;
	logic	req_a;
	logic	req_b;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rs1_r <= 1'b0;
			rs2_r <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rs2_r <= rs1_r;
		end
	end

	edge_if	ev_a ();
	edge_if	ev_b ();

	// Raw outputs cross through two flops before edge detection
	cmp_edge_sync u_sync_a (.clock(clock), .rst_sync_n(rs2_r),
		.raw(cmp_a_raw), .ev(ev_a.src));
	cmp_edge_sync u_sync_b (.clock(clock), .rst_sync_n(rs2_r),
		.raw(cmp_b_raw), .ev(ev_b.src));

	always_comb begin
		ctl_a_rd = st_r.ctl_a;
		ctl_a_rd[cmp_regs_pkg::BIT_RESULT] = ev_a.level;
		ctl_b_rd = st_r.ctl_b;
		ctl_b_rd[cmp_regs_pkg::BIT_RESULT] = ev_b.level;
	end

	always_comb begin
		req_a = (st_r.ctl_a[cmp_regs_pkg::BIT_RISE]
			& st_r.mode_a[cmp_regs_pkg::BIT_RISE_EN])
			| (st_r.ctl_a[cmp_regs_pkg::BIT_FALL]
			& st_r.mode_a[cmp_regs_pkg::BIT_FALL_EN]);
		req_b = (st_r.ctl_b[cmp_regs_pkg::BIT_RISE]
			& st_r.mode_b[cmp_regs_pkg::BIT_RISE_EN])
			| (st_r.ctl_b[cmp_regs_pkg::BIT_FALL]
			& st_r.mode_b[cmp_regs_pkg::BIT_FALL_EN]);
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = '0;
		if (wr_stb) begin
			unique case (addr)
			cmp_regs_pkg::ADDR_CMP0_CONTROL: begin
				// Writable bits, flags only clear where zero is written
				st_nxt.ctl_a = (wdata & cmp_regs_pkg::MASK_CONTROL_WR)
					| (wdata & st_r.ctl_a & cmp_regs_pkg::MASK_FLAGS);
			end
			cmp_regs_pkg::ADDR_CMP1_CONTROL: begin
				st_nxt.ctl_b = (wdata & cmp_regs_pkg::MASK_CONTROL_WR)
					| (wdata & st_r.ctl_b & cmp_regs_pkg::MASK_FLAGS);
			end
			cmp_regs_pkg::ADDR_CMP0_MODE_SELECT: begin
				st_nxt.mode_a = wdata & cmp_regs_pkg::MASK_MODE;
			end
			cmp_regs_pkg::ADDR_CMP1_MODE_SELECT: begin
				st_nxt.mode_b = wdata & cmp_regs_pkg::MASK_MODE;
			end
			cmp_regs_pkg::ADDR_CMP0_INPUT_SELECT: begin
				st_nxt.insel_a = wdata & cmp_regs_pkg::MASK_INPUT_SEL;
			end
			cmp_regs_pkg::ADDR_IRQ_STATUS: begin
				st_nxt.ist = st_r.ist & ~wdata[3:0];
			end
			cmp_regs_pkg::ADDR_IRQ_MASK: begin
				st_nxt.imask = wdata[3:0] & cmp_regs_pkg::MASK_IRQ;
			end
			default: begin
			end
			endcase
		end
		// Hardware set wins over a same-cycle software clear
		if (ev_a.rise) st_nxt.ctl_a[cmp_regs_pkg::BIT_RISE] = 1'b1;
		if (ev_a.fall) st_nxt.ctl_a[cmp_regs_pkg::BIT_FALL] = 1'b1;
		if (ev_b.rise) st_nxt.ctl_b[cmp_regs_pkg::BIT_RISE] = 1'b1;
		if (ev_b.fall) st_nxt.ctl_b[cmp_regs_pkg::BIT_FALL] = 1'b1;
		st_nxt.ist = st_nxt.ist | {ev_b.fall, ev_b.rise, ev_a.fall, ev_a.rise};
		if (rd_stb) begin
			unique case (addr)
			cmp_regs_pkg::ADDR_CMP0_CONTROL:      st_nxt.rdata = ctl_a_rd;
			cmp_regs_pkg::ADDR_CMP1_CONTROL:      st_nxt.rdata = ctl_b_rd;
			cmp_regs_pkg::ADDR_CMP0_MODE_SELECT:  st_nxt.rdata = st_r.mode_a;
			cmp_regs_pkg::ADDR_CMP1_MODE_SELECT:  st_nxt.rdata = st_r.mode_b;
			cmp_regs_pkg::ADDR_CMP0_INPUT_SELECT: st_nxt.rdata = st_r.insel_a;
			cmp_regs_pkg::ADDR_IRQ_STATUS:        st_nxt.rdata = {4'h0, st_r.ist};
			cmp_regs_pkg::ADDR_IRQ_MASK:          st_nxt.rdata = {4'h0, st_r.imask};
			default:                              st_nxt.rdata = 8'h00;
			endcase
		end
		// Port output forced low while disabled
		st_nxt.pin_a = st_nxt.ctl_a[cmp_regs_pkg::BIT_ON] & ev_a.level;
		st_nxt.pin_b = st_nxt.ctl_b[cmp_regs_pkg::BIT_ON] & ev_b.level;
		st_nxt.irq_a = req_a;
		st_nxt.irq_b = req_b;
		st_nxt.irq   = |(st_nxt.ist & st_nxt.imask);
	end

	always_ff @(posedge clock or negedge rs2_r) begin
		if (!rs2_r) begin
			st_r         <= '0;
			st_r.ctl_a   <= cmp_regs_pkg::RST_CONTROL;
			st_r.ctl_b   <= cmp_regs_pkg::RST_CONTROL;
			st_r.mode_a  <= cmp_regs_pkg::RST_MODE;
			st_r.mode_b  <= cmp_regs_pkg::RST_MODE;
			st_r.insel_a <= cmp_regs_pkg::RST_INPUT_SEL;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata           = st_r.rdata;
	assign cmp_a_on        = st_r.ctl_a[7];
	assign cmp_b_on        = st_r.ctl_b[7];
	assign cmp_a_pos_hyst  = st_r.ctl_a[3:2];
	assign cmp_a_neg_hyst  = st_r.ctl_a[1:0];
	assign cmp_b_pos_hyst  = st_r.ctl_b[3:2];
	assign cmp_b_neg_hyst  = st_r.ctl_b[1:0];
	assign cmp_a_neg_sel   = st_r.insel_a[6:4];
	assign cmp_a_pos_sel   = st_r.insel_a[2:0];
	assign cmp_a_speed_sel = st_r.mode_a[1:0];
	assign cmp_b_speed_sel = st_r.mode_b[1:0];
	assign cmp_a_pin_out   = st_r.pin_a;
	assign cmp_b_pin_out   = st_r.pin_b;
	assign cmp_a_irq       = st_r.irq_a;
	assign cmp_b_irq       = st_r.irq_b;
	assign irq             = st_r.irq;

	a_flag_sticky: assert property (@(posedge clock) disable iff (!rs2_r)
		st_r.ctl_a[5] && !(wr_stb && addr == cmp_regs_pkg::ADDR_CMP0_CONTROL)
		|=> st_r.ctl_a[5]) else $error("rise flag dropped");
	a_rise_sets: assert property (@(posedge clock) disable iff (!rs2_r)
		ev_a.rise |=> st_r.ctl_a[5]) else $error("rise flag not set");
	a_fall_sets: assert property (@(posedge clock) disable iff (!rs2_r)
		ev_b.fall |=> st_r.ctl_b[4]) else $error("fall flag not set");
	a_pin_low_off: assert property (@(posedge clock) disable iff (!rs2_r)
		!cmp_a_on |-> !cmp_a_pin_out) else $error("pin high while off");
	a_mode_unused: assert property (@(posedge clock) disable iff (!rs2_r)
		(st_r.mode_a & 8'hCC) == 8'h00) else $error("mode unused set");
	a_insel_unused: assert property (@(posedge clock) disable iff (!rs2_r)
		(st_r.insel_a & 8'h88) == 8'h00) else $error("insel unused set");
	a_irq_gate: assert property (@(posedge clock) disable iff (!rs2_r)
		!st_r.mode_a[5] && !st_r.mode_a[4] |=> !cmp_a_irq)
		else $error("irq while disabled");
	a_read_ctl: assert property (@(posedge clock) disable iff (!rs2_r)
		rd_stb && addr == cmp_regs_pkg::ADDR_CMP1_CONTROL
		|=> rdata[6] == $past(ev_b.level)) else $error("bad output bit");
	c_rise_a: cover property (@(posedge clock) ev_a.rise);
	c_fall_b: cover property (@(posedge clock) ev_b.fall);
	c_irq: cover property (@(posedge clock) irq);
endmodule

// File: rtl/edge_if.sv
`timescale 1ns/1ps
interface edge_if;
	logic	level;
	logic	rise;
	logic	fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

// File: testbench/comparator_control_regs_tb_top.sv
`timescale 1ns/1ps
module comparator_control_regs_tb_top;
	logic		clock = 1'b0;
	logic		rst_n = 1'b0;
	logic [7:0]	addr = 8'h00;
	logic [7:0]	wdata = 8'h00;
	logic		wr_stb = 1'b0;
	logic		rd_stb = 1'b0;
	logic		cmp_a_raw = 1'b0;
	logic		cmp_b_raw = 1'b0;
	logic [7:0]	rdata;
	logic		a_on, b_on, a_pin, b_pin, a_irq, b_irq, irq;
	logic [1:0]	a_ph, a_nh, b_ph, b_nh, a_sp, b_sp;
	logic [2:0]	a_ns, a_ps;
	int		err_count = 0;
	int		n_compared = 0;

	always #2 clock = ~clock;

	comparator_control_regs dut_u (
		.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.cmp_a_raw(cmp_a_raw), .cmp_b_raw(cmp_b_raw),
		.cmp_a_on(a_on), .cmp_b_on(b_on),
		.cmp_a_pos_hyst(a_ph), .cmp_a_neg_hyst(a_nh),
		.cmp_b_pos_hyst(b_ph), .cmp_b_neg_hyst(b_nh),
		.cmp_a_neg_sel(a_ns), .cmp_a_pos_sel(a_ps),
		.cmp_a_speed_sel(a_sp), .cmp_b_speed_sel(b_sp),
		.cmp_a_pin_out(a_pin), .cmp_b_pin_out(b_pin),
		.cmp_a_irq(a_irq), .cmp_b_irq(b_irq), .irq(irq));

	task automatic stop_test;
		$display("Mismatches %0d, comparisons %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
		// Let the register update land before any output is looked at
		#1;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic settle;
		repeat (3) @(posedge clock);
		#1;
	endtask

	// Waits for both synced pin outputs, then lets flags land
	task automatic wait_pin(input logic [1:0] exp);
		for (int i = 0; i < 12 && {b_pin, a_pin} !== exp; i++) begin
			@(posedge clock);
			#1;
		end
		if ({b_pin, a_pin} !== exp) begin
			err_count++;
			$display("FAIL %0t pin wait ran out", $time);
			stop_test();
		end
		settle();
	endtask

	task automatic t_reset;
		rd(8'h9A, 8'h00);
		rd(8'h9B, 8'h00);
		rd(8'h9D, 8'h02);
		rd(8'h9F, 8'h00);
		rd(8'hA2, 8'h02);
		rd(8'h55, 8'h00);
		chk({6'h00, a_sp}, 8'h02);
	endtask

	task automatic t_cfg;
		for (int c = 0; c < 5; c++) begin
			wr(8'h9D, 8'hFC | c[1:0]);
			rd(8'h9D, 8'h30 | c[1:0]);
			chk({6'h00, a_sp}, c[1:0]);
			wr(8'h9F, {1'b1, c[2:0], 1'b1, c[2:0]});
			rd(8'h9F, {1'b0, c[2:0], 1'b0, c[2:0]});
			chk({a_ns, 2'b00, a_ps}, {c[2:0], 2'b00, c[2:0]});
			wr(8'h9B, {4'h4, c[1:0], ~c[1:0]});
			rd(8'h9B, {4'h0, c[1:0], ~c[1:0]});
			chk({a_ph, a_nh}, {c[1:0], ~c[1:0]});
			wr(8'h9A, {4'h0, ~c[1:0], c[1:0]});
			chk({b_ph, b_nh}, {~c[1:0], c[1:0]});
		end
		wr(8'hA2, 8'hFF);
		rd(8'hA2, 8'h33);
		chk({6'h00, b_sp}, 8'h03);
		wr(8'h9D, 8'h02);
		wr(8'h9B, 8'h80);
		wr(8'h9A, 8'h80);
		chk({b_on, a_on}, 8'h03);
	endtask

	task automatic t_edge;
		cmp_a_raw <= 1'b1;
		wait_pin(2'b01);
		rd(8'h9B, 8'hE0);
		cmp_a_raw <= 1'b0;
		wait_pin(2'b00);
		rd(8'h9B, 8'hB0);
		wr(8'h9B, 8'hB0);
		rd(8'h9B, 8'hB0);
		wr(8'h9B, 8'h80);
		settle();
		rd(8'h9B, 8'h80);
		cmp_b_raw <= 1'b1;
		wait_pin(2'b10);
		rd(8'h9A, 8'hE0);
		wr(8'h9A, 8'h00);
		settle();
		chk({7'h00, b_pin}, 8'h00);
	endtask

	task automatic t_irq;
		wr(8'hA0, 8'h0F);
		wr(8'h9D, 8'h22);
		cmp_a_raw <= 1'b1;
		wait_pin(2'b01);
		chk({7'h00, a_irq}, 8'h01);
		wr(8'h9D, 8'h12);
		settle();
		chk({7'h00, a_irq}, 8'h00);
		cmp_a_raw <= 1'b0;
		wait_pin(2'b00);
		chk({7'h00, a_irq}, 8'h01);
		wr(8'h9D, 8'h02);
		settle();
		chk({7'h00, a_irq}, 8'h00);
		rd(8'hA0, 8'h03);
		chk({7'h00, irq}, 8'h00);
		wr(8'hA1, 8'h01);
		settle();
		chk({7'h00, irq}, 8'h01);
		wr(8'hA0, 8'h01);
		settle();
		chk({7'h00, irq}, 8'h00);
		rd(8'hA0, 8'h02);
		wr(8'hA2, 8'h12);
		cmp_b_raw <= 1'b0;
		settle();
		settle();
		chk({7'h00, b_irq}, 8'h01);
	endtask

	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		t_reset();
		t_cfg();
		t_edge();
		t_irq();
		stop_test();
	end

	initial begin
		#100000;
		err_count++;
		$display("FAIL %0t run limit reached", $time);
		stop_test();
	end
endmodule
